// ### inc/ddm_pkg.sv
// Shared constants of the driver diagnostics monitor
package ddm_pkg;
  // Coil and measurement widths
  localparam int COILS = 3;
  localparam int COIL_W = 8;
  localparam int LOAD_W = 10;
  localparam int CS_W = 5;
  localparam int GATE_W = 2;
  localparam int STAT_W = 20;
  // Coil current magnitude below this is too low to judge a coil (1/16 of full scale)
  localparam int COIL_FULL = 2 ** COIL_W;
  localparam logic [COIL_W-1:0] CUR_LOW_LIM = COIL_W'(COIL_FULL / 16);
  // Load result range and reset value (light load)
  localparam logic [LOAD_W-1:0] LOAD_MAX = 10'h3ff;
  localparam logic [LOAD_W-1:0] LOAD_ZERO = 10'h000;
  // Fullsteps per raw measurement and samples averaged in filtered mode
  localparam logic [1:0] STEPS_PER_MEAS = 2'h2;
  localparam logic [1:0] FILT_SAMPLES = 2'h3;
  // Divide by three as multiply and shift, exact for sums below 8192
  localparam logic [23:0] DIV3_MUL = 24'h000aab;
  localparam int DIV3_SHIFT = 13;
  localparam int ACC_W = 12;
  // Gate current settings that receive temperature compensation
  localparam logic [3:0] GATE_TC_MASK = 4'h6;
  localparam logic [GATE_W-1:0] GATE_MAX = 2'h3;
  // Current scale reset value
  localparam logic [CS_W-1:0] CS_RESET = 5'h00;
  // Indexes of asynchronous pins in the synchroniser
  localparam int PIN_VCC = 0;
  localparam int PIN_VS = 1;
  localparam int PIN_TPW = 2;
  localparam int PIN_TSD = 3;
  localparam int PIN_SCK = 4;
  localparam int PIN_CSN = 5;
  localparam int PIN_SDI = 6;
  localparam int PINS = 7;
  // Status response word layout
  localparam int ST_SHUT = 0;
  localparam int ST_PREW = 1;
  localparam int ST_OPEN_LSB = 2;
  localparam int ST_CS_LSB = 5;
  localparam int ST_LOAD_LSB = 10;
endpackage : ddm_pkg

// ### inc/ddm_coil_if.sv
// Per-coil activity and open coil result between top and detector
`timescale 1ns/1ps
`default_nettype none
interface ddm_coil_if;
  logic polarity;
  logic chop_evt;
  logic target_miss;
  logic cur_low;
  logic fullstep;
  logic clear;
  logic open_flag;
  modport src (output polarity, output chop_evt, output target_miss, output cur_low,
               output fullstep, output clear, input open_flag);
  modport mon (input polarity, input chop_evt, input target_miss, input cur_low,
               input fullstep, input clear, output open_flag);
endinterface : ddm_coil_if
`default_nettype wire

// ### src/ddm_open_load.sv
// Open coil detector for one phase
`timescale 1ns/1ps
`default_nettype none
module ddm_open_load (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Coil activity
  ddm_coil_if.mon cif
);
  typedef struct packed {
    logic pol_q;
    logic chop_seen;
    logic miss_seen;
    logic flag;
  } ddm_ol_s;

  ddm_ol_s st_ff;
  ddm_ol_s nxt_st;
  logic toggle;

  ////////////////////////////////////////////////////////////////
  // Interval bookkeeping and flag update
  assign toggle = cif.polarity ^ st_ff.pol_q;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pol_q = cif.polarity;
    if (cif.clear) begin
      nxt_st = '0;
      nxt_st.pol_q = cif.polarity;
    end else if (toggle) begin
      // Too little current gives no chopper events, so keep old flag
      if (!cif.cur_low) begin
        nxt_st.flag = !st_ff.chop_seen || (cif.fullstep && st_ff.miss_seen);
      end
      // Event in the toggle cycle belongs to the new interval
      nxt_st.chop_seen = cif.chop_evt;
      nxt_st.miss_seen = cif.target_miss;
    end else begin
      nxt_st.chop_seen = st_ff.chop_seen | cif.chop_evt;
      nxt_st.miss_seen = st_ff.miss_seen | cif.target_miss;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cif.open_flag = st_ff.flag;
endmodule : ddm_open_load
`default_nettype wire

// ### src/ddm_load_filter.sv
// Load measurement sampler with optional three-sample average
`timescale 1ns/1ps
`default_nettype none
module ddm_load_filter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Control
  input wire logic clear,
  input wire logic filter_en,
  // Raw measurement
  input wire logic fullstep_pulse,
  input wire logic [ddm_pkg::LOAD_W-1:0] raw_value,
  // Result
  output logic [ddm_pkg::LOAD_W-1:0] result,
  output logic updated
);
  import ddm_pkg::*;

  typedef struct packed {
    logic [1:0] step_cnt;
    logic [1:0] samp_cnt;
    logic [ACC_W-1:0] acc;
    logic [LOAD_W-1:0] res;
    logic upd;
  } ddm_lf_s;

  ddm_lf_s st_ff;
  ddm_lf_s nxt_st;
  logic [ACC_W-1:0] sum;

  // Average of three samples
  function automatic logic [LOAD_W-1:0] avg3(input logic [ACC_W-1:0] s);
    logic [23:0] prod;
    prod = 24'(s) * DIV3_MUL;
    avg3 = LOAD_W'(prod >> DIV3_SHIFT);
  endfunction : avg3

  ////////////////////////////////////////////////////////////////
  // Sample every second fullstep, publish direct or averaged
  assign sum = st_ff.acc + ACC_W'(raw_value);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.upd = 1'b0;
    if (clear) begin
      nxt_st = '0;
      nxt_st.res = LOAD_MAX;
    end else if (fullstep_pulse) begin
      if (st_ff.step_cnt == STEPS_PER_MEAS - 2'h1) begin
        nxt_st.step_cnt = 2'h0;
        if (!filter_en) begin
          nxt_st.res = raw_value;
          nxt_st.upd = 1'b1;
          nxt_st.acc = '0;
          nxt_st.samp_cnt = 2'h0;
        end else if (st_ff.samp_cnt == FILT_SAMPLES - 2'h1) begin
          nxt_st.res = avg3(sum);
          nxt_st.upd = 1'b1;
          nxt_st.acc = '0;
          nxt_st.samp_cnt = 2'h0;
        end else begin
          nxt_st.acc = sum;
          nxt_st.samp_cnt = st_ff.samp_cnt + 2'h1;
        end
      end else begin
        nxt_st.step_cnt = st_ff.step_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      st_ff.res <= LOAD_MAX;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign result = st_ff.res;
  assign updated = st_ff.upd;
endmodule : ddm_load_filter
`default_nettype wire

// ### src/ddm_top.sv
// Driver diagnostics monitor: open coil, temperature, undervoltage, load, status readout
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Open coil flag set when no chopper event in the last constant polarity interval.
// - Each phase re-evaluates its open coil flag at every polarity toggle.
// - Open coil flag held while coil current is below one sixteenth of full scale.
// - In fullstep mode a missed target current within a step also flags open coil.
// - Prewarning flag follows the lower temperature comparator; driver keeps running.
// - Upper temperature comparator switches driver off and sets shutdown flag.
// - Compensated gate settings get one step more drive while prewarning is active.
// - Logic supply low or driver supply low both mean undervoltage.
// - Undervoltage resets control logic, disables driver, turns all MOSFETs off.
// - During undervoltage serial output is zero and nothing shifts through.
// - Undervoltage clears current scale; host reads it back as zero.
// - Load result falls toward zero as mechanical load rises.
// - Stall pin is high while load result reads zero.
// - Load result is unsigned 0 to 1023, larger meaning lighter load.
// - Load result updates every two fullsteps, or averages three over six.
module ddm_top #(
  parameter logic [3:0] TC_MASK = ddm_pkg::GATE_TC_MASK
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Supply and temperature comparators, asynchronous
  input wire logic vcc_low_in,
  input wire logic vs_low_in,
  input wire logic temp_prewarn_in,
  input wire logic temp_shutdown_in,
  // Coil activity from chopper, core_clk domain
  input wire logic [ddm_pkg::COILS-1:0] coil_polarity,
  input wire logic [ddm_pkg::COILS-1:0] chop_event,
  input wire logic [ddm_pkg::COILS-1:0] target_miss,
  input wire logic [ddm_pkg::COILS-1:0][ddm_pkg::COIL_W-1:0] coil_current,
  input wire logic fullstep_mode,
  // Load measurement, core_clk domain
  input wire logic fullstep_pulse,
  input wire logic [ddm_pkg::LOAD_W-1:0] load_raw,
  input wire logic load_filter_enable,
  // Configuration, core_clk domain
  input wire logic cs_write,
  input wire logic [ddm_pkg::CS_W-1:0] cs_value,
  input wire logic [ddm_pkg::GATE_W-1:0] gate_setting,
  // Serial status readout, asynchronous pins
  input wire logic spi_sck,
  input wire logic spi_csn,
  input wire logic spi_sdi,
  output logic spi_sdo,
  // Diagnostics
  output logic [ddm_pkg::COILS-1:0] open_coil_flag,
  output logic heat_prewarn_flag,
  output logic heat_shutdown_flag,
  output logic undervoltage,
  // Load result
  output logic [ddm_pkg::LOAD_W-1:0] load_measure_result,
  output logic load_updated,
  output logic stall_indicator_pin,
  // Driver control
  output logic [ddm_pkg::CS_W-1:0] actual_current_scale_readback,
  output logic [ddm_pkg::GATE_W-1:0] gate_current_eff,
  output logic driver_enable,
  output logic mosfet_off
);
  import ddm_pkg::*;

  // All monitor state in one record; only the two synchroniser
  // stages touch pins, every other field is plain core_clk
  // state that the next-state logic may read directly
  typedef struct packed {
    logic [PINS-1:0] sync1;
    logic [PINS-1:0] sync2;
    logic sck_q;
    logic csn_q;
    logic [STAT_W-1:0] sr;
    logic sdo;
    logic prewarn;
    logic shutdown;
    logic uv;
    logic [CS_W-1:0] cs;
    logic [GATE_W-1:0] gate;
    logic stall;
    logic drv_en;
  } ddm_top_s;

  ddm_top_s st_ff;
  ddm_top_s nxt_st;

  // Combinational helpers
  logic [PINS-1:0] pins_raw;
  logic uv_now;
  logic [LOAD_W-1:0] load_res;
  logic load_upd;
  logic [COILS-1:0] open_flags;
  logic [STAT_W-1:0] status_word;
  logic sck_rise;
  logic csn_fall;

  // A warm chip already at the top setting keeps it; there is
  // no stronger drive left to step up to
  // Gate setting with temperature compensation, saturating at the top setting
  function automatic logic [GATE_W-1:0] gate_comp(input logic [GATE_W-1:0] setting,
                                                   input logic warm,
                                                   input logic [3:0] mask);
    gate_comp = setting;
    if (warm && mask[setting] && setting != GATE_MAX) begin
      gate_comp = setting + GATE_W'(1);
    end
  endfunction : gate_comp

  ////////////////////////////////////////////////////////////////
  // Pin collection for the synchroniser
  // Spare bits default to zero so the pin list can grow
  // without a stale bit reaching the second stage
  always_comb begin
    pins_raw = '0;
    pins_raw[PIN_VCC] = vcc_low_in;
    pins_raw[PIN_VS] = vs_low_in;
    pins_raw[PIN_TPW] = temp_prewarn_in;
    pins_raw[PIN_TSD] = temp_shutdown_in;
    pins_raw[PIN_SCK] = spi_sck;
    pins_raw[PIN_CSN] = spi_csn;
    pins_raw[PIN_SDI] = spi_sdi;
  end

  ////////////////////////////////////////////////////////////////
  // Undervoltage from either supply comparator
  // Not debounced: a pulse that survives both stages resets
  // the control logic, which is the safe direction to err
  assign uv_now = st_ff.sync2[PIN_VCC] | st_ff.sync2[PIN_VS];

  // Serial edges, seen only after the second synchroniser stage
  // Clock idles low and select idles high; the edge registers
  // reset to those levels so no edge appears after reset
  assign sck_rise = st_ff.sync2[PIN_SCK] & ~st_ff.sck_q;
  assign csn_fall = ~st_ff.sync2[PIN_CSN] & st_ff.csn_q;

  ////////////////////////////////////////////////////////////////
  // Open coil detectors, one per phase
  // Step mode is global, so all phases share the qualifier;
  // after undervoltage the first toggle judges a partial
  // interval, because the clear dropped all history
  for (genvar g = 0; g < COILS; g++) begin : g_coil
    ddm_coil_if cif();

    assign cif.polarity = coil_polarity[g];
    assign cif.chop_evt = chop_event[g];
    assign cif.target_miss = target_miss[g];
    // Strict compare: exactly one sixteenth is enough current
    assign cif.cur_low = coil_current[g] < CUR_LOW_LIM;
    assign cif.fullstep = fullstep_mode;
    assign cif.clear = st_ff.uv;
    assign open_flags[g] = cif.open_flag;

    ddm_open_load u_open (
      .core_clk (core_clk),
      .reset_n (reset_n),
      .cif (cif.mon)
    );
  end

  ////////////////////////////////////////////////////////////////
  // Load measurement sampler; cleared with the rest of control logic
  // After a clear the host reads full scale, meaning no load
  // known yet, rather than a value from before the dropout
  ddm_load_filter u_load (
    .core_clk (core_clk),
    .reset_n (reset_n),
    .clear (st_ff.uv),
    .filter_en (load_filter_enable),
    .fullstep_pulse (fullstep_pulse),
    .raw_value (load_raw),
    .result (load_res),
    .updated (load_upd)
  );

  ////////////////////////////////////////////////////////////////
  // Status response word
  // Bit layout, most significant first on the wire:
  //   19..10 load result
  //   9..5   current scale
  //   4..2   open coil flags, coil 2 down to coil 0
  //   1      prewarning
  //   0      shutdown
  // Captured whole at the select edge, so a flag that changes
  // during a frame only shows in the next frame
  always_comb begin
    status_word = '0;
    status_word[ST_SHUT] = st_ff.shutdown;
    status_word[ST_PREW] = st_ff.prewarn;
    status_word[ST_OPEN_LSB +: COILS] = open_flags;
    status_word[ST_CS_LSB +: CS_W] = st_ff.cs;
    status_word[ST_LOAD_LSB +: LOAD_W] = load_res;
  end

  ////////////////////////////////////////////////////////////////
  // Next state of the monitor
  always_comb begin
    nxt_st = st_ff;
    // Synchroniser and edge registers advance every cycle
    nxt_st.sync1 = pins_raw;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sck_q = st_ff.sync2[PIN_SCK];
    nxt_st.csn_q = st_ff.sync2[PIN_CSN];
    nxt_st.uv = uv_now;

    // Shutdown latches: a chip cooling below the upper
    // threshold stays off until reset or undervoltage, so the
    // driver never cycles on and off at the trip point
    // Temperature flags; shutdown holds until the next reset or undervoltage
    nxt_st.prewarn = st_ff.sync2[PIN_TPW];
    nxt_st.shutdown = st_ff.shutdown | st_ff.sync2[PIN_TSD];

    // A write in a cycle with undervoltage seen is lost, as
    // the clear further down overrides it
    // Current scale written by configuration logic
    if (cs_write) begin
      nxt_st.cs = cs_value;
    end

    // Effective high side gate current
    nxt_st.gate = gate_comp(gate_setting, st_ff.prewarn, TC_MASK);

    // Stall pin follows the published load result
    // One cycle behind the result, like the other flag outputs
    nxt_st.stall = load_res == LOAD_ZERO;

    // Uses the next shutdown value so the driver drops in the
    // same cycle as the flag rises, not one cycle later
    // Driver runs only without undervoltage and shutdown
    nxt_st.drv_en = !uv_now && !nxt_st.shutdown;

    // The host must hold each clock level for one core clock or more,
    // so the first stage samples it; the later stages only add delay.
    // Faster serial clocks lose edges without any warning.
    // After twenty clocks the received bits reach the output,
    // so a longer frame echoes what the host sent
    // Serial readout: load on select, shift on clock rise
    if (st_ff.sync2[PIN_CSN]) begin
      nxt_st.sdo = 1'b0;
    end else if (csn_fall) begin
      nxt_st.sr = status_word;
      nxt_st.sdo = status_word[STAT_W-1];
    end else if (sck_rise) begin
      // Received bits pass through behind the status word
      nxt_st.sr = {st_ff.sr[STAT_W-2:0], st_ff.sync2[PIN_SDI]};
      nxt_st.sdo = st_ff.sr[STAT_W-2];
    end

    // Placed last so it overrides the current scale, shutdown, gate and serial updates above; the
    // open coil detectors and the load sampler take the
    // registered flag as their clear, one cycle later
    // Undervoltage: control logic back to reset, link silent
    if (uv_now) begin
      nxt_st.cs = CS_RESET;
      nxt_st.shutdown = 1'b0;
      // Weakest gate drive while the supplies are low
      nxt_st.gate = '0;
      // Stall keeps following the result, which the sampler clears
      nxt_st.sr = '0;
      nxt_st.sdo = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // State register
  // Asynchronous reset loads constants only; undervoltage
  // takes the synchronous path through the next-state logic
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      // Select idles high; a zero here would fake a select edge
      st_ff.sync1[PIN_CSN] <= 1'b1;
      st_ff.sync2[PIN_CSN] <= 1'b1;
      st_ff.sck_q <= 1'b0;
      st_ff.csn_q <= 1'b1;
      st_ff.cs <= CS_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  // Every output comes straight from a flip-flop, except the
  // gate-off level, which is one inverter on the enable
  // Status bits are also brought out as levels for local use
  assign spi_sdo = st_ff.sdo;
  assign open_coil_flag = open_flags;
  assign heat_prewarn_flag = st_ff.prewarn;
  assign heat_shutdown_flag = st_ff.shutdown;
  assign undervoltage = st_ff.uv;
  assign load_measure_result = load_res;
  assign load_updated = load_upd;
  assign stall_indicator_pin = st_ff.stall;
  assign actual_current_scale_readback = st_ff.cs;
  assign gate_current_eff = st_ff.gate;
  assign driver_enable = st_ff.drv_en;
  // MOSFETs off whenever the driver is not enabled
  assign mosfet_off = ~st_ff.drv_en;
endmodule : ddm_top
`default_nettype wire

// ### tb/ddm_top_sva.sv
// Concurrent checks on the diagnostics monitor ports
`timescale 1ns/1ps
`default_nettype none
module ddm_top_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Watched inputs
  input wire logic vcc_low_in,
  input wire logic vs_low_in,
  input wire logic temp_prewarn_in,
  input wire logic [ddm_pkg::COILS-1:0] coil_polarity,
  input wire logic cs_write,
  input wire logic [ddm_pkg::CS_W-1:0] cs_value,
  // Watched outputs
  input wire logic spi_sdo,
  input wire logic [ddm_pkg::COILS-1:0] open_coil_flag,
  input wire logic heat_prewarn_flag,
  input wire logic heat_shutdown_flag,
  input wire logic undervoltage,
  input wire logic [ddm_pkg::LOAD_W-1:0] load_measure_result,
  input wire logic load_updated,
  input wire logic stall_indicator_pin,
  input wire logic [ddm_pkg::CS_W-1:0] actual_current_scale_readback,
  input wire logic driver_enable,
  input wire logic mosfet_off
);
  import ddm_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Driver and supply
  AST_MOSFET_OFF: assert property (mosfet_off == !driver_enable)
    else $error("mosfet_off not inverse of driver_enable");
  AST_UV_DRV: assert property (undervoltage |-> !driver_enable)
    else $error("driver still enabled in undervoltage");
  AST_UV_SDO: assert property (undervoltage |-> !spi_sdo)
    else $error("serial output not zero in undervoltage");
  AST_UV_CS: assert property (undervoltage |-> actual_current_scale_readback == CS_RESET)
    else $error("current scale not cleared by undervoltage");
  // Supply pins low keep the write from racing the synchroniser
  AST_CS_TAKE: assert property (cs_write && !undervoltage && !vcc_low_in && !vs_low_in
    |=> actual_current_scale_readback == $past(cs_value))
    else $error("current scale write not taken");
  ////////////////////////////////////////////////////////////////////////////////
  // Temperature
  AST_PREWARN: assert property (temp_prewarn_in [*5] |-> heat_prewarn_flag)
    else $error("prewarning flag missing");
  AST_SHUT_OFF: assert property (heat_shutdown_flag |=> !driver_enable)
    else $error("driver on during shutdown");
  AST_SHUT_STICKY: assert property (heat_shutdown_flag && !undervoltage |=> heat_shutdown_flag || undervoltage)
    else $error("shutdown flag dropped");
  ////////////////////////////////////////////////////////////////////////////////
  // Open coil and load result
  AST_OPEN_HOLD: assert property ($changed(open_coil_flag[0])
    |-> $past(coil_polarity[0]) != $past(coil_polarity[0], 2) || undervoltage || $past(undervoltage))
    else $error("open flag changed without polarity toggle");
  AST_STALL: assert property (stall_indicator_pin == ($past(load_measure_result) == LOAD_ZERO))
    else $error("stall pin disagrees with load result");
  AST_LOAD_UPD: assert property ($changed(load_measure_result)
    |-> load_updated || $past(load_updated) || undervoltage || $past(undervoltage))
    else $error("load result changed without update");
  // Main scenarios reached
  COV_STALL: cover property ($rose(stall_indicator_pin));
  COV_OPEN: cover property ($rose(open_coil_flag[0]));
  COV_UV: cover property ($rose(undervoltage));
endmodule : ddm_top_sva
bind ddm_top ddm_top_sva ddm_top_sva_inst (.core_clk, .reset_n, .vcc_low_in, .vs_low_in, .temp_prewarn_in,
  .coil_polarity, .cs_write, .cs_value, .spi_sdo, .open_coil_flag, .heat_prewarn_flag, .heat_shutdown_flag,
  .undervoltage, .load_measure_result, .load_updated, .stall_indicator_pin, .actual_current_scale_readback,
  .driver_enable, .mosfet_off);
`default_nettype wire

// ### tb/ddm_host_model.sv
// Host side reader of the serial status word
`timescale 1ns/1ps
`default_nettype none
module ddm_host_model (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic spi_sck,
  output logic spi_csn,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  initial begin
    spi_sck = 1'b0;
    spi_csn = 1'b1;
    spi_sdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Each level held six clocks, longer than sync plus edge detect
  task automatic hold();
    repeat (6) @(negedge core_clk);
  endtask : hold
  // One frame, most significant bit first; sdi toggles so a pass-through shows
  task automatic read_status(output logic [ddm_pkg::STAT_W-1:0] word);
    int i;
    spi_csn = 1'b0;
    hold();
    for (i = ddm_pkg::STAT_W - 1; i >= 0; i--) begin
      word[i] = spi_sdo;
      spi_sdi = ~spi_sdi;
      spi_sck = 1'b1;
      hold();
      spi_sck = 1'b0;
      hold();
    end
    spi_csn = 1'b1;
    hold();
  endtask : read_status
endmodule : ddm_host_model
`default_nettype wire

// ### tb/ddm_top_tb.sv
// Self-checking bench of the diagnostics monitor
`timescale 1ns/1ps
`default_nettype none
module ddm_top_tb;
  import ddm_pkg::*;
  logic core_clk, reset_n, vcc_low_in, vs_low_in, temp_prewarn_in, temp_shutdown_in;
  logic [COILS-1:0] coil_polarity, chop_event, target_miss, open_coil_flag;
  logic [COILS-1:0][COIL_W-1:0] coil_current;
  logic fullstep_mode, fullstep_pulse, load_filter_enable, cs_write;
  logic [LOAD_W-1:0] load_raw, load_measure_result;
  logic [CS_W-1:0] cs_value, actual_current_scale_readback;
  logic [GATE_W-1:0] gate_setting, gate_current_eff;
  logic spi_sck, spi_csn, spi_sdi, spi_sdo, heat_prewarn_flag, heat_shutdown_flag, undervoltage;
  logic load_updated, stall_indicator_pin, driver_enable, mosfet_off;
  logic [STAT_W-1:0] word;
  int err_total, compares;
  ////////////////////////////////////////////////////////////////////////////////
  ddm_top ddm_top_inst (.core_clk, .reset_n, .vcc_low_in, .vs_low_in, .temp_prewarn_in, .temp_shutdown_in,
    .coil_polarity, .chop_event, .target_miss, .coil_current, .fullstep_mode, .fullstep_pulse, .load_raw,
    .load_filter_enable, .cs_write, .cs_value, .gate_setting, .spi_sck, .spi_csn, .spi_sdi, .spi_sdo,
    .open_coil_flag, .heat_prewarn_flag, .heat_shutdown_flag, .undervoltage, .load_measure_result,
    .load_updated, .stall_indicator_pin, .actual_current_scale_readback, .gate_current_eff, .driver_enable,
    .mosfet_off);
  ddm_host_model ddm_host_model_inst (.core_clk, .spi_sck, .spi_csn, .spi_sdi, .spi_sdo);
  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask : step
  task automatic toggle();
    coil_polarity[0] = ~coil_polarity[0];
    step(2);
  endtask : toggle
  // Two fullsteps carrying one raw value; upd tells whether the second one publishes
  task automatic fstep(input logic [LOAD_W-1:0] v, input logic upd);
    int i;
    load_raw = v;
    for (i = 0; i < 2; i++) begin
      fullstep_pulse = 1'b1;
      step(1);
      fullstep_pulse = 1'b0;
      chk(load_updated, upd && i == 1);
      step(3);
    end
  endtask : fstep
  task automatic final_report();
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_cs();
    cs_write = 1'b1;
    cs_value = 5'h1b;
    step(1);
    cs_value = 5'h15;
    chk(actual_current_scale_readback, 5'h1b);
    step(1);
    cs_write = 1'b0;
    chk(actual_current_scale_readback, 5'h15);
  endtask : t_cs
  task automatic t_open();
    toggle();
    chk(open_coil_flag, 3'b001);
    chop_event[0] = 1'b1;
    step(1);
    chop_event[0] = 1'b0;
    toggle();
    chk(open_coil_flag, 3'b000);
    coil_current[0] = CUR_LOW_LIM - 8'h01;
    toggle();
    chk(open_coil_flag, 3'b000);
    coil_current[0] = CUR_LOW_LIM;
    fullstep_mode = 1'b1;
    chop_event[0] = 1'b1;
    target_miss[0] = 1'b1;
    step(1);
    chop_event[0] = 1'b0;
    target_miss[0] = 1'b0;
    toggle();
    chk(open_coil_flag, 3'b001);
    fullstep_mode = 1'b0;
  endtask : t_open
  task automatic t_load();
    fstep(LOAD_ZERO, 1'b1);
    chk({load_measure_result, stall_indicator_pin}, {LOAD_ZERO, 1'b1});
    fstep(LOAD_MAX, 1'b1);
    chk({load_measure_result, stall_indicator_pin}, {LOAD_MAX, 1'b0});
    load_filter_enable = 1'b1;
    fstep(10'h001, 1'b0);
    fstep(10'h002, 1'b0);
    chk(load_measure_result, LOAD_MAX);
    fstep(10'h006, 1'b1);
    chk(load_measure_result, 10'h003);
  endtask : t_load
  task automatic t_status();
    ddm_host_model_inst.read_status(word);
    chk(word, {10'h003, 5'h15, 3'b001, 2'b00});
  endtask : t_status
  task automatic t_temp();
    int s;
    for (s = 0; s < 4; s++) begin
      gate_setting = GATE_W'(s);
      temp_prewarn_in = 1'b0;
      step(8);
      chk(gate_current_eff, s);
      temp_prewarn_in = 1'b1;
      step(8);
      chk({heat_prewarn_flag, driver_enable}, 2'b11);
      chk(gate_current_eff, s + (GATE_TC_MASK[s] && s < 3));
    end
    temp_prewarn_in = 1'b0;
    temp_shutdown_in = 1'b1;
    step(8);
    temp_shutdown_in = 1'b0;
    step(8);
    chk({heat_shutdown_flag, driver_enable, mosfet_off}, 3'b101);
  endtask : t_temp
  // Either supply low; a write during it must be ignored
  task automatic t_uv();
    int k;
    for (k = 0; k < 2; k++) begin
      {vcc_low_in, vs_low_in} = k ? 2'b01 : 2'b10;
      step(8);
      cs_write = 1'b1;
      cs_value = 5'h0a;
      step(1);
      cs_write = 1'b0;
      step(2);
      chk({undervoltage, driver_enable, mosfet_off, heat_shutdown_flag}, 4'b1010);
      chk(actual_current_scale_readback, CS_RESET);
      ddm_host_model_inst.read_status(word);
      chk(word, '0);
      {vcc_low_in, vs_low_in} = 2'b00;
      step(8);
      chk({driver_enable, mosfet_off}, 2'b10);
      ddm_host_model_inst.read_status(word);
      chk(word, {LOAD_MAX, 10'h000});
    end
  endtask : t_uv
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {vcc_low_in, vs_low_in, temp_prewarn_in, temp_shutdown_in} = '0;
    {coil_polarity, chop_event, target_miss} = '0;
    coil_current = {COILS{CUR_LOW_LIM}};
    {fullstep_mode, fullstep_pulse, load_filter_enable, cs_write} = '0;
    load_raw = LOAD_MAX;
    cs_value = CS_RESET;
    gate_setting = 2'h0;
    err_total = 0;
    compares = 0;
    reset_n = 1'b0;
    step(16);
    reset_n = 1'b1;
    step(4);
    t_cs();
    t_open();
    t_load();
    t_status();
    t_temp();
    t_uv();
    final_report();
  end
endmodule : ddm_top_tb
`default_nettype wire
